// File: intc_consts.svh
// constants for the posted interrupt clear and post block
// assumes inclusion by bare name from design files only
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

`define NUM_SRC            8
`define SRC_W              3
`define ADDR_POST_CLEAR    12'h0DA
`define ADDR_CONTROL       12'h0E0
`define ADDR_IRQ_STATUS    12'h0E4
`define ADDR_IRQ_MASK      12'h0E8
`define ADDR_WIDTH         12
`define RESET_POSTED       8'h00
`define RESET_MASK         8'h00
`define CTRL_SWINT_BIT     0
`define BIT_SERIAL_SLAVE   7
`define BIT_SLEEP_TIMER    6
`define BIT_SPI            5
`define BIT_PINS           4
`define BIT_TIMER_ZERO     3
`define BIT_TOUCH          2
`define BIT_ANALOG         1
`define BIT_SUPPLY_MON     0
`define DATA_ZERO          32'h00000000

`endif

// File: intc_pkg.sv
// types for the posted interrupt clear and post block
// assumes intc_consts.svh is visible
`include "intc_consts.svh"
package intc_pkg;
  typedef logic [`NUM_SRC-1:0] src_vec_t;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_CLEAR,
    OP_POST
  } write_op_t;
endpackage : intc_pkg

// File: intc_sources.sv
// peripheral sources: one-cycle event and acknowledge pulses
// assumes the bench holds each request for one pclk cycle
`timescale 1ns/1ns
`default_nettype none
module intc_sources (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] fire_req,
  input  wire logic [7:0] ack_req,
  output logic      [7:0] src_event,
  output logic      [7:0] src_ack
);
  // registered so pulses change just after an edge, never mid-cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_event <= 8'h00;
      src_ack   <= 8'h00;
    end else begin
      src_event <= fire_req;
      src_ack   <= ack_req;
    end
  end
endmodule : intc_sources
`default_nettype wire

// File: post_flag.sv
// one posted interrupt flag
// assumes synchronous single-cycle event and write strobes
`timescale 1ns/1ns
`default_nettype none
`include "intc_consts.svh"
module post_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hw_event,
  input  wire logic ack,
  input  wire logic sw_clear,
  input  wire logic sw_post,
  output logic      posted
);
  typedef struct packed {
    logic posted;
  } flag_state_t;

  flag_state_t state_reg;
  flag_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // set beats clear so no event is lost
    if (ack || sw_clear) begin
      state_next.posted = 1'b0;
    end
    if (hw_event || sw_post) begin
      state_next.posted = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign posted = state_reg.posted;

  a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    hw_event |=> posted)
    else $error("hardware event did not post");
endmodule : post_flag
`default_nettype wire

// File: posted_interrupt_clear_post.sv
// posted interrupt clear and post register with apb slave
// assumes apb master on pclk; sources give one-cycle event pulses
//
// Overview of operation
// - a read of the clear register returns one for each source with a posted interrupt, zero elsewhere.
// - writing zero with software interrupt enable clear clears that source's posted interrupt.
// - writing zero to a source with nothing posted changes nothing.
// - writing one with software interrupt enable set posts an interrupt for that source.
// - writing one with software interrupt enable clear leaves the source unchanged.
// - writing zero with software interrupt enable set leaves the source unchanged.
// - bits 7..0 map to serial slave, sleep timer, spi, pins, timer zero, touch, analog, supply monitor.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "intc_consts.svh"
module posted_interrupt_clear_post (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  src_event,
  input  wire logic [7:0]  src_ack,
  output logic [7:0]       posted,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] rdata;
    logic        swint_en;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [7:0]  posted_prev;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  // register select, reused by read mux and write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  logic               access;
  logic               rd_setup;
  logic               wr;
  logic               mapped;
  intc_pkg::src_vec_t sw_clear;
  intc_pkg::src_vec_t sw_post;
  intc_pkg::write_op_t op;
  intc_pkg::src_vec_t new_post;

  assign access   = psel && penable;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr       = access && pwrite && pstrb[0];
  assign mapped = hit(paddr, `ADDR_POST_CLEAR) || hit(paddr, `ADDR_CONTROL) ||
                  hit(paddr, `ADDR_IRQ_STATUS) || hit(paddr, `ADDR_IRQ_MASK);
  // zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // mode decides whether zeros clear or ones post, never both
  always_comb begin
    op = intc_pkg::OP_NONE;
    if (wr && hit(paddr, `ADDR_POST_CLEAR)) begin
      op = state_reg.swint_en ? intc_pkg::OP_POST : intc_pkg::OP_CLEAR;
    end
  end

  // zero clears, one posts; other combinations leave flags alone
  assign sw_clear = (op == intc_pkg::OP_CLEAR) ? ~pwdata[7:0] : '0;
  assign sw_post  = (op == intc_pkg::OP_POST)  ?  pwdata[7:0] : '0;

  // bit order of src_event follows the register layout
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++) begin : g_flag
      post_flag u_flag (
        .pclk     (pclk),
        .presetn  (presetn),
        .hw_event (src_event[g]),
        .ack      (src_ack[g]),
        .sw_clear (sw_clear[g]),
        .sw_post  (sw_post[g]),
        .posted   (posted[g])
      );
    end
  endgenerate

  assign new_post = posted & ~state_reg.posted_prev;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.posted_prev = posted;
    // caught in setup so the flop already shows it in the access cycle
    if (rd_setup) begin
      state_next.rdata = `DATA_ZERO;
      if (hit(paddr, `ADDR_POST_CLEAR)) begin
        state_next.rdata[7:0] = posted;
      end else if (hit(paddr, `ADDR_CONTROL)) begin
        state_next.rdata[`CTRL_SWINT_BIT] = state_reg.swint_en;
      end else if (hit(paddr, `ADDR_IRQ_STATUS)) begin
        state_next.rdata[7:0] = state_reg.irq_status;
      end else if (hit(paddr, `ADDR_IRQ_MASK)) begin
        state_next.rdata[7:0] = state_reg.irq_mask;
      end
    end
    if (wr && hit(paddr, `ADDR_CONTROL)) begin
      state_next.swint_en = pwdata[`CTRL_SWINT_BIT];
    end
    if (wr && hit(paddr, `ADDR_IRQ_MASK)) begin
      state_next.irq_mask = pwdata[7:0];
    end
    if (wr && hit(paddr, `ADDR_IRQ_STATUS)) begin
      state_next.irq_status = state_reg.irq_status & ~pwdata[7:0];
    end
    // new posting wins over a same-cycle clear
    state_next.irq_status = state_next.irq_status | new_post;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // read data comes out of a flop loaded in setup; stands through the access cycle
  assign prdata = state_reg.rdata;
  assign irq    = |(state_reg.irq_status & state_reg.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_clear_write(int b);
    wr && hit(paddr, `ADDR_POST_CLEAR) && !state_reg.swint_en && !pwdata[b] && !src_event[b];
  endsequence

  sequence s_flag_rise(int b);
    !posted[b] ##1 posted[b];
  endsequence

  a_read_returns_posted: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit(paddr, `ADDR_POST_CLEAR)) |=> prdata[7:0] == $past(posted))
    else $error("read does not return posted flags");

  a_zero_clears_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_clear_write(`BIT_SPI) |=> !posted[`BIT_SPI])
    else $error("zero write did not clear");

  a_clear_idle_stays: assert property (@(posedge pclk) disable iff (!presetn)
    (s_clear_write(`BIT_PINS) and !posted[`BIT_PINS]) |=> !posted[`BIT_PINS])
    else $error("clear of idle flag changed it");

  a_one_posts_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, `ADDR_POST_CLEAR) && state_reg.swint_en && pwdata[`BIT_SERIAL_SLAVE])
      |=> posted[`BIT_SERIAL_SLAVE])
    else $error("one write did not post");

  a_one_no_post: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, `ADDR_POST_CLEAR) && !state_reg.swint_en && pwdata[`BIT_ANALOG] &&
     !posted[`BIT_ANALOG] && !src_event[`BIT_ANALOG]) |=> !posted[`BIT_ANALOG])
    else $error("one write posted with mode off");

  a_zero_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, `ADDR_POST_CLEAR) && state_reg.swint_en && !pwdata[`BIT_TOUCH] &&
     posted[`BIT_TOUCH] && !src_ack[`BIT_TOUCH]) |=> posted[`BIT_TOUCH])
    else $error("zero write cleared in post mode");

  a_sleep_map: assert property (@(posedge pclk) disable iff (!presetn)
    (src_event[`BIT_SLEEP_TIMER] && !posted[`BIT_SLEEP_TIMER])
      |=> posted[`BIT_SLEEP_TIMER] ##1 state_reg.irq_status[`BIT_SLEEP_TIMER])
    else $error("sleep source not on its bit");

  a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (posted[`BIT_TIMER_ZERO] && !src_ack[`BIT_TIMER_ZERO] && sw_clear[`BIT_TIMER_ZERO] == 1'b0)
      |=> posted[`BIT_TIMER_ZERO])
    else $error("posted flag dropped without clear");

  a_rise_sets_status: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_rise(`BIT_PINS) |=> state_reg.irq_status[`BIT_PINS])
    else $error("newly posted flag did not set status");

  a_ack_clears_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (src_ack[`BIT_SUPPLY_MON] && !src_event[`BIT_SUPPLY_MON] && !sw_post[`BIT_SUPPLY_MON])
      |=> !posted[`BIT_SUPPLY_MON])
    else $error("acknowledge did not clear");

  a_other_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && !hit(paddr, `ADDR_POST_CLEAR) && posted[`BIT_ANALOG] && !src_ack[`BIT_ANALOG])
      |=> posted[`BIT_ANALOG])
    else $error("write elsewhere dropped a flag");
endmodule : posted_interrupt_clear_post
`default_nettype wire

// File: tb_posted_interrupt_clear_post.sv
// self-checking bench for the posted interrupt clear and post register
// assumes the design files and intc_sources.sv are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module tb_posted_interrupt_clear_post;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  fire_req, ack_req, src_event, src_ack, posted, m;
  int          failures, check_count, cyc, mp, st, mk;
  posted_interrupt_clear_post i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .src_ack(src_ack), .posted(posted), .irq(irq));
  intc_sources i_src (.pclk(pclk), .presetn(presetn), .fire_req(fire_req), .ack_req(ack_req),
    .src_event(src_event), .src_ack(src_ack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // one apb transfer; request held until pready is seen high, read data taken at that edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  // model: status bit rises with each newly posted flag
  function automatic void set_p(input int v);
    st = st | (v & ~mp & 'hFF);
    mp = v & 'hFF;
  endfunction : set_p
  task automatic check_all();
    bus(1'b0, 12'h0DA, 32'h00000000);
    `CHK(rd, 32'(mp))
    `CHK(err, 1'b0)
    `CHK(posted, 8'(mp))
    bus(1'b0, 12'h0E4, 32'h00000000);
    `CHK(rd, 32'(st))
    `CHK(irq, 1'(|(st & mk)))
  endtask : check_all
  // event wins over a same-cycle acknowledge
  task automatic pulse(input logic [7:0] f, input logic [7:0] k);
    @(posedge pclk);
    fire_req <= f;
    ack_req  <= k;
    @(posedge pclk);
    fire_req <= 8'h00;
    ack_req  <= 8'h00;
    repeat (3) @(posedge pclk);
    set_p((mp & ~k) | f);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // under three hundred cycles suffice; a hang ends here
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fire_req, ack_req, presetn} = '0;
    pstrb = 4'hF;
    void'($urandom(72));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 8'h00);
      check_all();
    end
    bus(1'b1, 12'h0E8, 32'h000000FF);
    mk = 'hFF;
    for (int i = 0; i < 6; i++) begin
      pulse(8'($urandom), 8'h00);
      m = 8'($urandom);
      bus(1'b1, 12'h0DA, {24'h000000, m});
      set_p(mp & m);
      check_all();
    end
    pulse(8'h00, 8'($urandom));
    check_all();
    bus(1'b1, 12'h0E0, 32'h00000001);
    bus(1'b1, 12'h0E4, 32'h000000FF);
    st = 0;
    for (int i = 0; i < 6; i++) begin
      m = 8'($urandom);
      bus(1'b1, 12'h0DA, {24'h000000, m});
      set_p(mp | m);
      check_all();
    end
    bus(1'b0, 12'h0F0, 32'h00000000);
    `CHK(err, 1'b1)
    bus(1'b1, 12'h0E8, 32'h00000000);
    mk = 0;
    check_all();
    complete_run();
  end
endmodule : tb_posted_interrupt_clear_post
`default_nettype wire
